// ### rtl/lpcfc_defines.vh
// Shared constants of the LPC flash pin control front end
`ifndef LPCFC_DEFINES_VH
`define LPCFC_DEFINES_VH

`define LPCFC_ST_W 4
`define LPCFC_ST_IDLE 4'h0
`define LPCFC_ST_CYC 4'h1
`define LPCFC_ST_ADDR 4'h2
`define LPCFC_ST_WDATA 4'h3
`define LPCFC_ST_TAR1 4'h4
`define LPCFC_ST_TAR2 4'h5
`define LPCFC_ST_SYNC 4'h6
`define LPCFC_ST_RDATA 4'h7
`define LPCFC_ST_TARB1 4'h8
`define LPCFC_ST_TARB2 4'h9
`define LPCFC_ST_SKIP 4'hA

`define LPCFC_LAD_START 4'h0
`define LPCFC_CT_MEM 2'h1
`define LPCFC_CT_DIR_BIT 1
`define LPCFC_SYNC_READY 4'h0
`define LPCFC_TAR_DRIVE 4'hF
`define LPCFC_ADDR_LAST 3'h7
`define LPCFC_NIB_LAST 3'h1

`define LPCFC_SEL_HI 21
`define LPCFC_SEL_LO 19
`define LPCFC_BLK_HI 18
`define LPCFC_BLK_LO 16
`define LPCFC_TOP_BLOCK 3'h7

`define LPCFC_REG_AW 4
`define LPCFC_REG_LOCK 4'h0
`define LPCFC_REG_GPI 4'h1
`define LPCFC_REG_STATUS 4'h2
`define LPCFC_REG_PROT 4'h3
`define LPCFC_LOCK_RST 8'h00
`define LPCFC_STAT_LPC 0
`define LPCFC_STAT_READ 1
`define LPCFC_STAT_REJ 2
`define LPCFC_STAT_BUSY 3

`endif

// ### rtl/lpcfc_reset_ctl.v
// Internal reset combine and interface select capture
`timescale 1ns/1ps
`include "lpcfc_defines.vh"
module lpcfc_reset_ctl (
  input wire clk,
  input wire sys_rst,
  input wire interface_reset_n,
  input wire cpu_reset_n,
  input wire interface_select,
  output wire int_rst,
  output wire lpc_sel
);
  reg captured_r;
  reg lpc_sel_r;

  assign int_rst = ~interface_reset_n | ~cpu_reset_n;
  assign lpc_sel = lpc_sel_r;

  // Select is caught on the first edge after power-up and during reset only
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      captured_r <= 1'b0;
      lpc_sel_r <= 1'b1;
    end else if (!captured_r || int_rst) begin
      captured_r <= 1'b1;
      lpc_sel_r <= ~interface_select;
    end
  end
endmodule // lpcfc_reset_ctl

// ### rtl/lpcfc_block_protect.v
// Per-block hardware and lock register write protection
`timescale 1ns/1ps
`include "lpcfc_defines.vh"
module lpcfc_block_protect #(
  parameter NBLK = 8
) (
  input wire [NBLK-1:0] lock_bits,
  input wire top_block_lock_n,
  input wire main_block_protect_n,
  input wire [2:0] blk,
  output wire [NBLK-1:0] prot_vec,
  output wire blk_prot
);
  genvar i;
  generate
    for (i = 0; i < NBLK; i = i + 1) begin : g_blk
      if (i == `LPCFC_TOP_BLOCK) begin : g_top
        assign prot_vec[i] = ~top_block_lock_n | lock_bits[i];
      end else begin : g_main
        assign prot_vec[i] = ~main_block_protect_n | lock_bits[i];
      end
    end
  endgenerate

  assign blk_prot = prot_vec[blk];
endmodule // lpcfc_block_protect

// ### rtl/lpcfc_pin_control.v
// LPC flash pin control: frame tracking, chip select, reset, protection
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "lpcfc_defines.vh"
module lpcfc_pin_control #(
  parameter NBLK = 8,
  parameter MEM_AW = 19
) (
  input wire clk,
  input wire sys_rst,
  input wire lframe_n,
  input wire [3:0] lad_in,
  output wire [3:0] lad_out,
  output wire lad_oe,
  input wire [2:0] chip_ident_straps,
  input wire [4:0] general_inputs,
  input wire interface_select,
  input wire interface_reset_n,
  input wire cpu_reset_n,
  input wire top_block_lock_n,
  input wire main_block_protect_n,
  input wire [`LPCFC_REG_AW-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  output wire [MEM_AW-1:0] mem_addr,
  input wire [7:0] mem_rdata,
  output wire prog_stb,
  output wire [7:0] prog_data,
  input wire leave_read_mode,
  output wire read_mode
);
  wire int_rst;
  wire lpc_sel;
  wire [NBLK-1:0] prot_vec;
  wire blk_prot;
  wire [31:0] addr_full;
  wire id_hit;

  reg [`LPCFC_ST_W-1:0] st_r;
  reg [`LPCFC_ST_W-1:0] st_nxt;
  reg [2:0] cnt_r;
  reg [2:0] cnt_nxt;
  reg [31:0] addr_r;
  reg wr_r;
  reg [3:0] wlow_r;
  reg [7:0] rdata_r;
  reg [3:0] lad_out_r;
  reg [3:0] lad_out_nxt;
  reg lad_oe_r;
  reg lad_oe_nxt;
  reg prog_stb_r;
  reg [7:0] prog_data_r;
  reg rej_r;
  reg read_mode_r;
  reg [NBLK-1:0] lock_r;
  reg [7:0] reg_rdata_r;
  reg [7:0] rd_mux;

  lpcfc_reset_ctl u_rst (
    .clk(clk),
    .sys_rst(sys_rst),
    .interface_reset_n(interface_reset_n),
    .cpu_reset_n(cpu_reset_n),
    .interface_select(interface_select),
    .int_rst(int_rst),
    .lpc_sel(lpc_sel)
  );

  lpcfc_block_protect #(
    .NBLK(NBLK)
  ) u_prot (
    .lock_bits(lock_r),
    .top_block_lock_n(top_block_lock_n),
    .main_block_protect_n(main_block_protect_n),
    .blk(addr_r[`LPCFC_BLK_HI:`LPCFC_BLK_LO]),
    .prot_vec(prot_vec),
    .blk_prot(blk_prot)
  );

  // Address as it stands once the last nibble is on the lines
  assign addr_full = {addr_r[27:0], lad_in};
  assign id_hit = (addr_full[`LPCFC_SEL_HI:`LPCFC_SEL_LO] == ~chip_ident_straps);

  assign lad_out = lad_out_r;
  assign lad_oe = lad_oe_r & ~int_rst;
  assign mem_addr = addr_r[MEM_AW-1:0];
  assign prog_stb = prog_stb_r;
  assign prog_data = prog_data_r;
  assign read_mode = read_mode_r;
  assign reg_rdata = reg_rdata_r;

  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (!lpc_sel) begin
      st_nxt = `LPCFC_ST_IDLE;
      cnt_nxt = 3'h0;
    end else if (!lframe_n) begin
      // A low frame restarts decoding and drops any operation in flight
      st_nxt = (lad_in == `LPCFC_LAD_START) ? `LPCFC_ST_CYC : `LPCFC_ST_IDLE;
      cnt_nxt = 3'h0;
    end else begin
      case (st_r)
        `LPCFC_ST_IDLE: begin
          st_nxt = `LPCFC_ST_IDLE;
        end
        `LPCFC_ST_CYC: begin
          if (lad_in[3:2] == `LPCFC_CT_MEM) begin
            st_nxt = `LPCFC_ST_ADDR;
          end else begin
            st_nxt = `LPCFC_ST_SKIP;
          end
        end
        `LPCFC_ST_ADDR: begin
          if (cnt_r == `LPCFC_ADDR_LAST) begin
            cnt_nxt = 3'h0;
            if (!id_hit) begin
              st_nxt = `LPCFC_ST_SKIP;
            end else if (wr_r) begin
              st_nxt = `LPCFC_ST_WDATA;
            end else begin
              st_nxt = `LPCFC_ST_TAR1;
            end
          end else begin
            cnt_nxt = cnt_r + 3'h1;
          end
        end
        `LPCFC_ST_WDATA: begin
          if (cnt_r == `LPCFC_NIB_LAST) begin
            cnt_nxt = 3'h0;
            st_nxt = `LPCFC_ST_TAR1;
          end else begin
            cnt_nxt = cnt_r + 3'h1;
          end
        end
        `LPCFC_ST_TAR1: begin
          st_nxt = `LPCFC_ST_TAR2;
        end
        `LPCFC_ST_TAR2: begin
          st_nxt = `LPCFC_ST_SYNC;
        end
        `LPCFC_ST_SYNC: begin
          cnt_nxt = 3'h0;
          st_nxt = wr_r ? `LPCFC_ST_TARB1 : `LPCFC_ST_RDATA;
        end
        `LPCFC_ST_RDATA: begin
          if (cnt_r == `LPCFC_NIB_LAST) begin
            cnt_nxt = 3'h0;
            st_nxt = `LPCFC_ST_TARB1;
          end else begin
            cnt_nxt = cnt_r + 3'h1;
          end
        end
        `LPCFC_ST_TARB1: begin
          st_nxt = `LPCFC_ST_TARB2;
        end
        `LPCFC_ST_TARB2: begin
          st_nxt = `LPCFC_ST_IDLE;
        end
        `LPCFC_ST_SKIP: begin
          st_nxt = `LPCFC_ST_SKIP;
        end
        default: begin
          st_nxt = `LPCFC_ST_IDLE;
          cnt_nxt = 3'h0;
        end
      endcase
    end
  end

  // Drive values are prepared one edge ahead so the pins change on the clock
  always @* begin
    lad_oe_nxt = 1'b0;
    lad_out_nxt = `LPCFC_TAR_DRIVE;
    case (st_nxt)
      `LPCFC_ST_SYNC: begin
        lad_oe_nxt = 1'b1;
        lad_out_nxt = `LPCFC_SYNC_READY;
      end
      `LPCFC_ST_RDATA: begin
        lad_oe_nxt = 1'b1;
        lad_out_nxt = (cnt_nxt == 3'h0) ? rdata_r[3:0] : rdata_r[7:4];
      end
      `LPCFC_ST_TARB1: begin
        lad_oe_nxt = 1'b1;
        lad_out_nxt = `LPCFC_TAR_DRIVE;
      end
      default: begin
        lad_oe_nxt = 1'b0;
        lad_out_nxt = `LPCFC_TAR_DRIVE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= `LPCFC_ST_IDLE;
      cnt_r <= 3'h0;
      addr_r <= 32'h00000000;
      wr_r <= 1'b0;
      wlow_r <= 4'h0;
      rdata_r <= 8'h00;
      lad_out_r <= `LPCFC_TAR_DRIVE;
      lad_oe_r <= 1'b0;
      prog_stb_r <= 1'b0;
      prog_data_r <= 8'h00;
    end else if (int_rst) begin
      st_r <= `LPCFC_ST_IDLE;
      cnt_r <= 3'h0;
      wr_r <= 1'b0;
      lad_out_r <= `LPCFC_TAR_DRIVE;
      lad_oe_r <= 1'b0;
      prog_stb_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lad_out_r <= lad_out_nxt;
      lad_oe_r <= lad_oe_nxt;
      prog_stb_r <= 1'b0;
      if (st_r == `LPCFC_ST_CYC && lframe_n) begin
        wr_r <= lad_in[`LPCFC_CT_DIR_BIT];
      end
      if (st_r == `LPCFC_ST_ADDR && lframe_n) begin
        addr_r <= addr_full;
      end
      if (st_r == `LPCFC_ST_WDATA && lframe_n) begin
        if (cnt_r == `LPCFC_NIB_LAST) begin
          prog_data_r <= {lad_in, wlow_r};
          prog_stb_r <= ~blk_prot;
        end else begin
          wlow_r <= lad_in;
        end
      end
      if (st_r == `LPCFC_ST_TAR2) begin
        rdata_r <= mem_rdata;
      end
    end
  end

  // Rejected-write flag: a new rejection wins over a write-one clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rej_r <= 1'b0;
    end else if (st_r == `LPCFC_ST_WDATA && lframe_n && !int_rst &&
                 cnt_r == `LPCFC_NIB_LAST && blk_prot) begin
      rej_r <= 1'b1;
    end else if (reg_wr && reg_addr == `LPCFC_REG_STATUS && reg_wdata[`LPCFC_STAT_REJ]) begin
      rej_r <= 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_mode_r <= 1'b1;
    end else if (int_rst) begin
      read_mode_r <= 1'b1;
    end else if (leave_read_mode) begin
      read_mode_r <= 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_r <= `LPCFC_LOCK_RST;
    end else if (int_rst) begin
      lock_r <= `LPCFC_LOCK_RST;
    end else if (reg_wr && reg_addr == `LPCFC_REG_LOCK) begin
      lock_r <= reg_wdata[NBLK-1:0];
    end
  end

  always @* begin
    rd_mux = 8'h00;
    case (reg_addr)
      `LPCFC_REG_LOCK: begin
        rd_mux = lock_r;
      end
      `LPCFC_REG_GPI: begin
        rd_mux = {3'h0, general_inputs};
      end
      `LPCFC_REG_STATUS: begin
        rd_mux[`LPCFC_STAT_LPC] = lpc_sel;
        rd_mux[`LPCFC_STAT_READ] = read_mode_r;
        rd_mux[`LPCFC_STAT_REJ] = rej_r;
        rd_mux[`LPCFC_STAT_BUSY] = (st_r != `LPCFC_ST_IDLE);
      end
      `LPCFC_REG_PROT: begin
        rd_mux = prot_vec;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux;
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end
endmodule // lpcfc_pin_control

// ### dv/lpcfc_pin_control_assertions.sv
// Port checker for the LPC flash pin control
`timescale 1ns/1ps
module lpcfc_chk #(
  parameter MEM_AW = 19
) (
  input wire clk,
  input wire sys_rst,
  input wire lframe_n,
  input wire [3:0] lad_out,
  input wire lad_oe,
  input wire [4:0] general_inputs,
  input wire interface_reset_n,
  input wire cpu_reset_n,
  input wire top_block_lock_n,
  input wire main_block_protect_n,
  input wire [3:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [MEM_AW-1:0] mem_addr,
  input wire prog_stb,
  input wire read_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire up = interface_reset_n && cpu_reset_n;
  a_rst_no_drive: assert property (!interface_reset_n |-> !lad_oe)
    else $error("lad driven in reset");
  a_cpu_no_drive: assert property (!cpu_reset_n |-> !lad_oe)
    else $error("lad driven in cpu reset");
  a_rst_read_mode: assert property (!cpu_reset_n |=> read_mode)
    else $error("no read mode after reset");
  a_frame_quiet: assert property (!lframe_n |=> !lad_oe)
    else $error("lad driven after frame low");
  a_sync_first: assert property ($rose(lad_oe) |-> lad_out == 4'h0)
    else $error("first nibble not sync");
  a_oe_release: assert property ($rose(lad_oe) |-> ##[2:4] !lad_oe)
    else $error("lad held too long");
  a_top_guard: assert property (prog_stb && mem_addr[18:16] == 3'h7
    |-> top_block_lock_n) else $error("top block written while locked");
  a_main_guard: assert property (prog_stb && mem_addr[18:16] != 3'h7
    |-> main_block_protect_n) else $error("main block written while protected");
  a_gpi_value: assert property (up && reg_rd && reg_addr == 4'h1
    |=> reg_rdata == {3'h0, $past(general_inputs)}) else $error("input register wrong");
endmodule // lpcfc_chk

bind lpcfc_pin_control lpcfc_chk #(.MEM_AW(MEM_AW)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .lframe_n(lframe_n), .lad_out(lad_out), .lad_oe(lad_oe), .general_inputs(general_inputs),
  .interface_reset_n(interface_reset_n), .cpu_reset_n(cpu_reset_n),
  .top_block_lock_n(top_block_lock_n), .main_block_protect_n(main_block_protect_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
  .prog_stb(prog_stb), .read_mode(read_mode));

// ### dv/lpcfc_lpc_host.sv
// Host controller model driving the LPC side
`timescale 1ns/1ps
module lpcfc_lpc_host (
  input wire clk,
  input wire [3:0] lad_out,
  input wire lad_oe,
  output reg lframe_n,
  output wire [3:0] lad_in
);
  reg [3:0] drv_r;
  reg hoe_r;
  // Bus pull-ups leave released lines at all ones
  assign lad_in = lad_oe ? lad_out : (hoe_r ? drv_r : 4'hF);
  initial begin
    lframe_n = 1'b1;
    hoe_r = 1'b0;
    drv_r = 4'hF;
  end
  task nib(input [3:0] v);
    begin
      @(posedge clk);
      drv_r <= v;
    end
  endtask
  // Abort after ab address nibbles when ab is non-zero
  task xfer(input wr, input [31:0] a, input [7:0] d, input [3:0] ab,
            output [7:0] q, output integer seen);
    integer i;
    begin
      seen = 0;
      q = 8'h00;
      @(posedge clk);
      lframe_n <= 1'b0;
      hoe_r <= 1'b1;
      drv_r <= 4'h0;
      nib({2'b01, wr, 1'b0});
      lframe_n <= 1'b1;
      for (i = 0; i < ((ab != 0) ? ab : 8); i = i + 1)
        nib(a[31-4*i -: 4]);
      if (ab != 0) begin
        @(posedge clk);
        lframe_n <= 1'b0;
        drv_r <= 4'hF;
      end else begin
        if (wr) begin
          nib(d[3:0]);
          nib(d[7:4]);
        end
        nib(4'hF);
      end
      @(posedge clk);
      lframe_n <= 1'b1;
      hoe_r <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge clk);
        #1;
        if (lad_oe === 1'b1) begin
          if (seen > 0 && seen < 3) q[seen*4-4 +: 4] = lad_in;
          seen = seen + 1;
        end
      end
    end
  endtask
endmodule // lpcfc_lpc_host

// ### dv/tb_top.sv
// Self-checking bench of the LPC flash pin control
`timescale 1ns/1ps
module tb_top;
  reg clk, sys_rst, irst_n, crst_n, isel, tbl_n, wp_n, reg_wr, reg_rd, lrm;
  reg [2:0] ids;
  reg [4:0] gpi;
  reg [3:0] ra;
  reg [7:0] wd, mrd, q;
  wire lfr_n, oe, pstb, rmode;
  wire [3:0] lin, lout;
  wire [7:0] rdat, pdat;
  wire [18:0] maddr;
  integer err_count = 0, checked = 0, pcnt = 0, n, k;
  lpcfc_pin_control dut (.clk(clk), .sys_rst(sys_rst), .lframe_n(lfr_n), .lad_in(lin),
    .lad_out(lout), .lad_oe(oe), .chip_ident_straps(ids), .general_inputs(gpi),
    .interface_select(isel), .interface_reset_n(irst_n), .cpu_reset_n(crst_n),
    .top_block_lock_n(tbl_n), .main_block_protect_n(wp_n), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat), .mem_addr(maddr),
    .mem_rdata(mrd), .prog_stb(pstb), .prog_data(pdat), .leave_read_mode(lrm),
    .read_mode(rmode));
  lpcfc_lpc_host host (.clk(clk), .lad_out(lout), .lad_oe(oe), .lframe_n(lfr_n),
    .lad_in(lin));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    mrd <= maddr[7:0] ^ 8'h5A;
    if (pstb === 1'b1) pcnt <= pcnt + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rw(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk) begin reg_wr <= 1; ra <= a; wd <= d; end
      @(posedge clk) reg_wr <= 0;
    end
  endtask
  task rr(input [3:0] a, input [7:0] e);
    begin
      @(posedge clk) begin reg_rd <= 1; ra <= a; end
      @(posedge clk) reg_rd <= 0;
      #1 chk(rdat, e);
    end
  endtask
  task lx(input wr, input [2:0] s, input [2:0] b, input [3:0] ab, input [3:0] ns);
    integer sn;
    begin
      host.xfer(wr, {10'h0, s, b, 13'h0, b}, 8'hA5, ab, q, sn);
      chk(sn, ns);
      if (!wr && ns != 0) chk(q, {5'h0, b} ^ 8'h5A);
    end
  endtask
  task t_gpi;
    begin
      @(posedge clk) gpi <= 5'h15;
      rr(4'h1, 8'h15);
      rw(4'h1, 8'hFF);
      @(posedge clk) gpi <= 5'h0A;
      rr(4'h1, 8'h0A);
      rr(4'hF, 8'h00);
    end
  endtask
  task t_ident;
    begin
      for (n = 0; n < 8; n = n + 1) begin
        @(posedge clk) ids <= n[2:0];
        lx(0, ~n[2:0], 3'h2, 0, 4);
        lx(0, ~n[2:0] ^ 3'h4, 3'h2, 0, 0);
      end
      // A write to another chip must not reach the array
      k = pcnt;
      lx(1, 3'h3, 3'h2, 0, 0);
      chk(pcnt - k, 0);
      // Later scenarios address the boot memory
      @(posedge clk) ids <= 3'h0;
    end
  endtask
  task t_prot;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        // Pins settle before each write and hold through it
        @(posedge clk) begin tbl_n <= k[0]; wp_n <= k[1]; end
        rw(4'h0, k[2] ? 8'h88 : 8'h00);
        rr(4'h3, (k[2] ? 8'h88 : 8'h00) | {~k[0], {7{~k[1]}}});
        n = pcnt;
        lx(1, 3'h7, 3'h7, 0, 2);
        lx(1, 3'h7, 3'h3, 0, 2);
        chk(pcnt - n, (k[0] && !k[2]) + (k[1] && !k[2]));
      end
      chk(pdat, 8'hA5);
      rr(4'h2, 8'h07);
      rw(4'h2, 8'h04);
      rr(4'h2, 8'h03);
    end
  endtask
  task t_rst;
    begin
      lx(0, 3'h7, 3'h1, 3, 0);
      lx(0, 3'h7, 3'h1, 0, 4);
      @(posedge clk) lrm <= 1;
      @(posedge clk) lrm <= 0;
      rr(4'h2, 8'h01);
      chk(rmode, 1'b0);
      @(posedge clk) crst_n <= 0;
      repeat (3) @(posedge clk);
      crst_n <= 1;
      rr(4'h2, 8'h03);
      chk(rmode, 1'b1);
      rr(4'h3, 8'h00);
      @(posedge clk) begin isel <= 1; irst_n <= 0; end
      repeat (3) @(posedge clk);
      irst_n <= 1;
      repeat (2) @(posedge clk);
      isel <= 0;
      lx(0, 3'h7, 3'h1, 0, 0);
      rr(4'h2, 8'h02);
      @(posedge clk) irst_n <= 0;
      repeat (3) @(posedge clk);
      irst_n <= 1;
      repeat (2) @(posedge clk);
      lx(0, 3'h7, 3'h1, 0, 4);
    end
  endtask
  task close_out;
    begin
      $display("checked=%0d errors=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    sys_rst = 1; irst_n = 1; crst_n = 1; isel = 0; tbl_n = 1; wp_n = 1;
    reg_wr = 0; reg_rd = 0; lrm = 0; ids = 0; gpi = 0; ra = 0; wd = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    repeat (2) @(posedge clk);
    rr(4'h2, 8'h03);
    rr(4'h0, 8'h00);
    t_gpi;
    t_ident;
    t_prot;
    t_rst;
    close_out;
  end
  initial begin
    #40000;
    err_count = err_count + 1;
    close_out;
  end
endmodule // tb_top
